// file: scrd_pkg.sv
// Shared constants, lookup tables and carrier types for the strap clock ratio decoder
package scrd_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int REF_DIV_DEF    = 64;   // Clock cycles per reference tick
  // Ratio 12 with core 9:2 needs 54 core pulses per tick; fewer cycles let credit overflow
  localparam int REF_DIV_MIN    = 56;   // Below this the core chain overruns
  localparam int MEM_MULT_DEF   = 4;    // Memory PLL multiplier, plain default
  localparam int CORE_DEN       = 2;    // Core ratios are given in halves
  localparam int PLAT_DEN       = 1;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int        ADDR_W      = 4;
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_CTRL   = 4'h4;
  localparam logic [3:0] OFS_TICKS  = 4'h8;

  // Control fields and reset value
  localparam int         CTRL_RUN_BIT   = 0;
  localparam int         CTRL_CLR_BIT   = 1;
  localparam logic [1:0] CTRL_RESET_VAL = 2'h1;

  // Status fields
  localparam int ST_PLAT_LSB  = 0;
  localparam int ST_CORE_LSB  = 4;
  localparam int ST_ASYNC_BIT = 7;
  localparam int ST_BAD_BIT   = 8;
  localparam int ST_LATCH_BIT = 9;
  localparam int ST_RUN_BIT   = 10;
  localparam int ST_MULT_LSB  = 12;
  localparam int ST_NUM_LSB   = 16;

  // ----------------------------------------------------------------
  // Ratio tables: zero marks a reserved code
  // ----------------------------------------------------------------
  localparam logic [3:0] PLAT_MULT_LUT [16] = '{
    4'h0, 4'h0, 4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h0,
    4'h8, 4'h9, 4'hA, 4'h0, 4'hC, 4'h0, 4'h0, 4'h0};
  // Core to platform ratio in halves, indexed high, mid, low
  localparam logic [3:0] CORE_NUM_LUT [8] = '{
    4'h8, 4'h9, 4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] plat_code;
    logic [2:0] core_code;
    logic       mem_async;
  } scrd_straps_t;

  typedef struct packed {
    logic [3:0] plat_mult;
    logic [3:0] core_num;
    logic       bad;
  } scrd_ratio_t;

endpackage

// file: scrd_rate_nco.sv
// Credit based rate multiplier: emits num/den output ticks per input tick
`timescale 1ns/1ps
`default_nettype none
module scrd_rate_nco #(
  parameter int NUM_W  = 4,
  parameter int CRED_W = 8
) (
  // Clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              rst_n_in,
  // Control
  input  wire logic              enable_in,
  input  wire logic              in_tick_in,
  input  wire logic [NUM_W-1:0]  num_in,
  input  wire logic [NUM_W-1:0]  den_in,
  // Output
  output logic                   tick_out
);

  logic [CRED_W-1:0] credit_r;
  logic [CRED_W-1:0] sum;
  logic              fire;

  if (CRED_W <= NUM_W + 1)
  begin : g_chk
    $error("scrd_rate_nco: CRED_W too narrow");
  end

  // Add credit on each input tick; spend one denominator per output tick
  always_comb
  begin
    sum  = credit_r + (in_tick_in ? CRED_W'(num_in) : '0);
    fire = enable_in && (den_in != '0) && (sum >= CRED_W'(den_in));
  end

  // Credit is dropped while disabled so a restart begins clean
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      credit_r <= '0;
      tick_out <= 1'b0;
    end
    else if (!enable_in)
    begin
      credit_r <= '0;
      tick_out <= 1'b0;
    end
    else
    begin
      credit_r <= fire ? sum - CRED_W'(den_in) : sum;
      tick_out <= fire;
    end
  end

endmodule
`default_nettype wire

// file: scrd_strap_latch.sv
// Strap capture and ratio decode, held until the next power-up reset
`timescale 1ns/1ps
`default_nettype none
module scrd_strap_latch (
  // Clock and reset
  input  wire logic                 ref_clk_in,
  input  wire logic                 rst_n_in,
  // Capture
  input  wire logic                 capture_in,
  input  wire scrd_pkg::scrd_straps_t pins_in,
  // Held values
  output scrd_pkg::scrd_straps_t    straps_out,
  output scrd_pkg::scrd_ratio_t     ratio_out,
  output logic                      latched_out
);

  scrd_pkg::scrd_ratio_t dec;

  // Table decode; a zero entry is a reserved code
  always_comb
  begin
    dec.plat_mult = scrd_pkg::PLAT_MULT_LUT[pins_in.plat_code];  // see [R1] see [R3] see [R4]
    dec.core_num  = scrd_pkg::CORE_NUM_LUT[pins_in.core_code];   // see [R5] see [R6] see [R7]
    dec.bad       = (dec.plat_mult == '0) || (dec.core_num == '0); // see [R14]
  end

  // One capture after reset release; later pin motion is ignored
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      straps_out  <= '0;
      ratio_out   <= '{plat_mult: 4'h0, core_num: 4'h0, bad: 1'b1};
      latched_out <= 1'b0;
    end
    else if (capture_in && !latched_out)                      // see [R13]
    begin
      straps_out  <= pins_in;
      ratio_out   <= dec;
      latched_out <= 1'b1;
    end
  end

  // Spot checks of the decode tables against fixed codes
  plat_twelve_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (pins_in.plat_code == 4'hC) |-> (dec.plat_mult == 4'hC && !dec.bad)) // see [R4]
    else $error("platform code 1100 not decoded as 12");
  plat_resv_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (pins_in.plat_code inside {4'h0, 4'h1, 4'h2, 4'h7, 4'hB, 4'hD, 4'hE, 4'hF})
    |-> dec.bad)                                              // see [R3] see [R4]
    else $error("reserved platform code not flagged");
  core_map_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (pins_in.core_code == 3'h1) |-> (dec.core_num == 4'h9)) // see [R6]
    else $error("core code 001 not decoded as 9:2");
  core_resv_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (pins_in.core_code == 3'h2) |-> dec.bad)                 // see [R6]
    else $error("reserved core code not flagged");

endmodule
`default_nettype wire

// file: scrd_top.sv
// Power-up strap ratio decoder driving platform, core and memory clock enables
//
// Function
// [R1] Platform clock equals reference clock times the four-bit strap ratio.
// [R2] Board must drive every platform strap; there is no default ratio.
// [R3] Codes 3..6 give ratios 3..6; codes 0..2 and 7 reserved.
// [R4] Codes 8,9,A,C give 8,9,10,12; B,D,E,F reserved.
// [R5] Core ratio comes from three straps ordered high, middle, low.
// [R6] Core codes 000=4:1, 001=9:2, 011=3:2; 010 reserved.
// [R7] Core codes 100=2:1, 101=5:2, 110=3:1, 111=7:2.
// [R8] Core clock runs as a slave of the platform clock.
// [R9] Memory complex runs synchronous or asynchronous to the platform.
// [R10] Synchronous mode clocks memory buses at half the platform rate.
// [R11] Memory data rate is platform rate in sync, PLL rate in async.
// [R12] Asynchronous mode derives memory clock from the memory reference input.
// [R13] Straps latch once after power-up reset and then never change.
// [R14] Any reserved code flags invalid and keeps the generator stopped.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module scrd_top #(
  parameter int REF_DIV  = scrd_pkg::REF_DIV_DEF,
  parameter int MEM_MULT = scrd_pkg::MEM_MULT_DEF
) (
  // Clock and reset
  input  wire logic                         ref_clk_in,
  input  wire logic                         rst_n_in,
  // Strap pins
  input  wire logic [3:0]                   platform_ratio_strap_in,
  input  wire logic                         core_ratio_strap_high_in,
  input  wire logic                         core_ratio_strap_mid_in,
  input  wire logic                         core_ratio_strap_low_in,
  input  wire logic                         mem_async_strap_in,
  // Memory reference clock, sampled as a level
  input  wire logic                         memory_reference_clock_in,
  // Register port
  input  wire logic [scrd_pkg::ADDR_W-1:0]  reg_addr_in,
  input  wire logic [31:0]                  reg_wdata_in,
  input  wire logic                         reg_wr_in,
  input  wire logic                         reg_rd_in,
  output logic      [31:0]                  reg_rdata_out,
  // Clock enables and status
  output logic                              system_reference_clock_en_out,
  output logic                              platform_bus_clock_en_out,
  output logic                              core_clock_en_out,
  output logic                              mem_data_clock_en_out,
  output logic                              mem_bus_clock_en_out,
  output logic                              ratio_invalid_out,
  output logic                              straps_latched_out
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (REF_DIV < scrd_pkg::REF_DIV_MIN || REF_DIV > 255)
  begin : g_chk_div
    $error("scrd_top: REF_DIV out of range");
  end
  if (MEM_MULT < 1 || MEM_MULT > 15)
  begin : g_chk_mem
    $error("scrd_top: MEM_MULT out of range");
  end

  localparam logic [7:0] REF_LAST  = 8'(REF_DIV - 1);
  localparam logic [3:0] MEM_NUM   = 4'(MEM_MULT);
  localparam logic [3:0] PLAT_DEN4 = 4'(scrd_pkg::PLAT_DEN);
  localparam logic [3:0] CORE_DEN4 = 4'(scrd_pkg::CORE_DEN);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    S_LATCH,
    S_RUN,
    S_HOLD,
    S_FAULT
  } scrd_state_t;

  scrd_state_t            state_r;
  scrd_state_t            state_nxt;
  scrd_pkg::scrd_straps_t pins;
  scrd_pkg::scrd_straps_t straps;
  scrd_pkg::scrd_ratio_t  ratio;
  logic                   latched;
  logic                   running;
  logic [1:0]             ctrl_r;
  logic [7:0]             ref_cnt_r;
  logic                   ref_tick_r;
  logic                   plat_tick;
  logic                   core_tick;
  logic                   mem_ref_d_r;
  logic                   mem_ref_rise;
  logic                   mem_pll_tick;
  logic                   mem_data_sel;
  logic                   mem_phase_r;
  logic [31:0]            ticks_r;
  logic [31:0]            status;
  logic                   clr_req;

  // ----------------------------------------------------------------
  // Strap capture and decode
  // ----------------------------------------------------------------

  // Gather loose pins; core order is high, middle, low
  always_comb
  begin
    pins.plat_code = platform_ratio_strap_in;                 // see [R1]
    pins.core_code = {core_ratio_strap_high_in,
                      core_ratio_strap_mid_in,
                      core_ratio_strap_low_in};                // see [R5]
    pins.mem_async = mem_async_strap_in;                      // see [R9]
  end

  scrd_strap_latch u_latch (
    .ref_clk_in  (ref_clk_in),
    .rst_n_in    (rst_n_in),
    .capture_in  (state_r == S_LATCH),
    .pins_in     (pins),
    .straps_out  (straps),
    .ratio_out   (ratio),
    .latched_out (latched)
  );

  // ----------------------------------------------------------------
  // Control state machine
  // ----------------------------------------------------------------

  // A bad ratio parks the machine for good; only power-up reset leaves it
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      S_LATCH: state_nxt = S_HOLD;
      S_HOLD:
      begin
        if (ratio.bad)
          state_nxt = S_FAULT;                                // see [R14]
        else if (ctrl_r[scrd_pkg::CTRL_RUN_BIT])
          state_nxt = S_RUN;
      end
      S_RUN:
      begin
        if (!ctrl_r[scrd_pkg::CTRL_RUN_BIT])
          state_nxt = S_HOLD;
      end
      S_FAULT: state_nxt = S_FAULT;
      default: state_nxt = S_FAULT;
    endcase
  end

  // State register
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      state_r <= S_LATCH;
    else
      state_r <= state_nxt;
  end

  assign running = (state_r == S_RUN);

  // ----------------------------------------------------------------
  // Reference tick divider
  // ----------------------------------------------------------------

  // Models the reference clock as one enable every REF_DIV cycles
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ref_cnt_r  <= '0;
      ref_tick_r <= 1'b0;
    end
    else
    begin
      ref_tick_r <= (ref_cnt_r == REF_LAST);
      ref_cnt_r  <= (ref_cnt_r == REF_LAST) ? '0 : ref_cnt_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Platform and core rate multipliers
  // ----------------------------------------------------------------

  // Platform: ratio ticks per reference tick
  scrd_rate_nco u_plat (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .enable_in  (running),
    .in_tick_in (ref_tick_r),
    .num_in     (ratio.plat_mult),                            // see [R1]
    .den_in     (PLAT_DEN4),
    .tick_out   (plat_tick)
  );

  // Core: fed only by platform ticks so it tracks them exactly
  scrd_rate_nco u_core (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .enable_in  (running),
    .in_tick_in (plat_tick),                                  // see [R8]
    .num_in     (ratio.core_num),
    .den_in     (CORE_DEN4),
    .tick_out   (core_tick)
  );

  // ----------------------------------------------------------------
  // Memory clocking
  // ----------------------------------------------------------------

  // Edge detect on the memory reference level; the input is synchronous
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      mem_ref_d_r <= 1'b0;
    else
      mem_ref_d_r <= memory_reference_clock_in;
  end

  assign mem_ref_rise = memory_reference_clock_in && !mem_ref_d_r;

  // Memory PLL only runs in asynchronous mode
  scrd_rate_nco u_mem (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .enable_in  (running && straps.mem_async),
    .in_tick_in (mem_ref_rise),                               // see [R12]
    .num_in     (MEM_NUM),
    .den_in     (PLAT_DEN4),
    .tick_out   (mem_pll_tick)
  );

  // Data rate follows platform in sync mode, PLL in async mode
  assign mem_data_sel = straps.mem_async ? mem_pll_tick : plat_tick; // see [R9] see [R11]

  // Bus clock is every second data tick
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      mem_phase_r <= 1'b0;
    else if (!running)
      mem_phase_r <= 1'b0;
    else if (mem_data_sel)
      mem_phase_r <= !mem_phase_r;                            // see [R10]
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------

  // Enables are registered so downstream gating sees clean pulses
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      system_reference_clock_en_out <= 1'b0;
      platform_bus_clock_en_out     <= 1'b0;
      core_clock_en_out             <= 1'b0;
      mem_data_clock_en_out         <= 1'b0;
      mem_bus_clock_en_out          <= 1'b0;
      ratio_invalid_out             <= 1'b0;
      straps_latched_out            <= 1'b0;
    end
    else
    begin
      system_reference_clock_en_out <= ref_tick_r;
      platform_bus_clock_en_out     <= plat_tick;
      core_clock_en_out             <= core_tick;
      mem_data_clock_en_out         <= mem_data_sel;
      mem_bus_clock_en_out          <= mem_data_sel && mem_phase_r; // see [R10]
      ratio_invalid_out             <= latched && ratio.bad;        // see [R14]
      straps_latched_out            <= latched;
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------

  assign clr_req = reg_wr_in && (reg_addr_in == scrd_pkg::OFS_CTRL) &&
                   reg_wdata_in[scrd_pkg::CTRL_CLR_BIT];

  // Control: run enable plus a self-clearing count clear
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      ctrl_r <= scrd_pkg::CTRL_RESET_VAL;
    else if (reg_wr_in && reg_addr_in == scrd_pkg::OFS_CTRL)
      ctrl_r <= {1'b0, reg_wdata_in[scrd_pkg::CTRL_RUN_BIT]};
  end

  // Platform tick count; a tick in the clear cycle counts as one
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      ticks_r <= '0;
    else if (clr_req)
      ticks_r <= {31'h0, plat_tick};
    else if (plat_tick)
      ticks_r <= ticks_r + 32'h1;
  end

  // Status word built from latched straps, decode and run state
  always_comb
  begin
    status = '0;
    status[scrd_pkg::ST_PLAT_LSB +: 4] = straps.plat_code;
    status[scrd_pkg::ST_CORE_LSB +: 3] = straps.core_code;
    status[scrd_pkg::ST_ASYNC_BIT]     = straps.mem_async;
    status[scrd_pkg::ST_BAD_BIT]       = latched && ratio.bad;
    status[scrd_pkg::ST_LATCH_BIT]     = latched;
    status[scrd_pkg::ST_RUN_BIT]       = running;
    status[scrd_pkg::ST_MULT_LSB +: 4] = ratio.plat_mult;
    status[scrd_pkg::ST_NUM_LSB +: 4]  = ratio.core_num;
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      reg_rdata_out <= '0;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        scrd_pkg::OFS_STATUS: reg_rdata_out <= status;
        scrd_pkg::OFS_CTRL:   reg_rdata_out <= {30'h0, ctrl_r};
        scrd_pkg::OFS_TICKS:  reg_rdata_out <= ticks_r;
        default:              reg_rdata_out <= '0;
      endcase
    end
    else
      reg_rdata_out <= '0;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_ref_edge;
    running && ref_tick_r && !$past(ref_tick_r);
  endsequence

  sequence s_plat_burst;
    plat_tick [*3];
  endsequence

  strap_hold_a : assert property (latched && $past(latched) |-> $stable(straps)) // see [R13]
    else $error("latched straps changed after capture");

  plat_burst_a : assert property (s_ref_edge |=> s_plat_burst)   // see [R1]
    else $error("platform ticks missing after reference tick");

  core_slave_a : assert property (running && plat_tick |=> core_tick) // see [R8]
    else $error("core tick did not follow platform tick");

  core_only_a : assert property (!running |=> !core_tick)         // see [R8]
    else $error("core tick while generator stopped");

  invalid_stop_a : assert property (latched && ratio.bad |-> !running ##1 !plat_tick) // see [R14]
    else $error("generator ran with a reserved ratio");

  mem_half_a : assert property (mem_bus_clock_en_out |-> mem_data_clock_en_out &&
                                !$past(mem_phase_r, 1) == 1'b0)   // see [R10]
    else $error("memory bus tick not on alternate data tick");

  mem_sync_a : assert property (running && !straps.mem_async && plat_tick
                                |=> mem_data_clock_en_out)        // see [R11]
    else $error("sync memory data rate not equal to platform");

  mem_async_a : assert property (running && straps.mem_async && mem_ref_rise
                                 |=> mem_pll_tick)                // see [R12]
    else $error("async memory tick missing after reference edge");

  mem_src_a : assert property (straps.mem_async && !mem_pll_tick
                               |=> !mem_data_clock_en_out)        // see [R9]
    else $error("async memory tick without memory PLL tick");

endmodule
`default_nettype wire

// file: scrd_board_model.sv
// Board strap resistors and a free running memory reference clock source
`timescale 1ns/1ps
`default_nettype none
module scrd_board_model #(
  parameter int HALF = 8
) (
  // Clock
  input  wire logic       ref_clk_in,
  // Wanted strap levels: platform code, core code, async select
  input  wire logic [7:0] cfg_in,
  // Strap pins and memory reference
  output logic      [7:0] pins_out,
  output logic            mem_ref_out
);
  int cnt_r = 0;

  // Pull resistors keep every strap at a defined level, never floating
  assign pins_out = cfg_in;

  // Slow reference keeps its edges far beyond the minimum spacing
  initial mem_ref_out = 1'b0;
  always @(posedge ref_clk_in)
  begin
    cnt_r <= (cnt_r == HALF - 1) ? 0 : cnt_r + 1;
    if (cnt_r == HALF - 1)
    begin
      mem_ref_out <= ~mem_ref_out;
    end
  end
endmodule
`default_nettype wire

// file: strap_clock_ratio_decoder_tb_top.sv
// Self-checking bench for the strap clock ratio decoder
`timescale 1ns/1ps
`default_nettype none
module strap_clock_ratio_decoder_tb_top;
  localparam int RD = 128;
  localparam int MM = 4;
  // Stimulus and observed signals
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  cfg   = 8'h00;
  logic [7:0]  pins;
  logic        mref;
  logic [3:0]  addr  = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic [31:0] rdata;
  logic        ref_en, plat_en, core_en, mdat_en, mbus_en, bad, latched;
  int          miscompares = 0;
  int          checks = 0;
  int          cp, cc, cd, cb, ce, cr;
  logic [31:0] seed = 32'h7DA8468C;

  initial forever #2.5 clk = ~clk;

  scrd_board_model board (.ref_clk_in(clk), .cfg_in(cfg), .pins_out(pins), .mem_ref_out(mref));

  scrd_top #(.REF_DIV(RD), .MEM_MULT(MM)) dut (
    .ref_clk_in(clk), .rst_n_in(rst_n), .platform_ratio_strap_in(pins[7:4]),
    .core_ratio_strap_high_in(pins[3]), .core_ratio_strap_mid_in(pins[2]),
    .core_ratio_strap_low_in(pins[1]), .mem_async_strap_in(pins[0]),
    .memory_reference_clock_in(mref), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .system_reference_clock_en_out(ref_en), .platform_bus_clock_en_out(plat_en),
    .core_clock_en_out(core_en), .mem_data_clock_en_out(mdat_en),
    .mem_bus_clock_en_out(mbus_en), .ratio_invalid_out(bad), .straps_latched_out(latched));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Comparison with a tolerance, for counts that carry a fractional residue
  task automatic near(input string nm, input int exp, input int got, input int tol);
    checks++;
    if (got < exp - tol || got > exp + tol)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (exp !== got)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Counts pulses and memory reference rises over a window of settled samples
  task automatic win(input int len);
    logic pm;
    cp = 0; cc = 0; cd = 0; cb = 0; ce = 0; cr = 0;
    pm = mref;
    for (int i = 0; i < len; i++)
    begin
      @(posedge clk);
      #1;
      cp += plat_en; cc += core_en; cd += mdat_en; cb += mbus_en; cr += ref_en;
      ce += (mref && !pm);
      pm = mref;
    end
  endtask

  task automatic run_cfg(input int p, input int c, input logic a);
    int m, n, w;
    logic e;
    logic [31:0] s;
    m = (p inside {3, 4, 5, 6, 8, 9, 10, 12}) ? p : 0;
    n = (c == 0) ? 8 : (c == 1) ? 9 : (c == 2) ? 0 : c;
    e = (m == 0 || n == 0);
    @(posedge clk);
    rst_n <= 1'b0;
    cfg <= {p[3:0], c[2:0], a};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    cfg <= ~{p[3:0], c[2:0], a};
    rd_reg(4'h0, s);
    chk("plat code", p, s[3:0]);
    chk("core code", c, s[6:4]);
    chk("async", a, s[7]);
    chk("invalid", {e, e, 1'b1, 1'b1, !e}, {s[8], bad, s[9], latched, s[10]});
    chk("plat mult", m, s[15:12]);
    chk("core num", n, s[19:16]);
    w = 0;
    while (ref_en !== 1'b1 && w < RD + 4)
    begin
      @(posedge clk);
      #1;
      w++;
    end
    win(2 * RD);
    chk("ref pulses", 2, cr);
    chk("plat pulses", e ? 0 : 2 * m, cp);
    near("core pulses", e ? 0 : m * n, cc, 2);
    if (a)
      near("mem data", e ? 0 : ce * MM, cd, MM);
    else
      chk("mem data", e ? 0 : 2 * m, cd);
    near("mem bus", e ? 0 : (a ? ce * MM : 2 * m) / 2, cb, MM / 2 + 1);
    // Stop first, clear later: a tick in the clear cycle would count as one
    wr_reg(4'h4, {seed[31:2], 2'h0});
    repeat (2) @(posedge clk);
    wr_reg(4'h4, {seed[31:2], 2'h2});
    win(RD + 8);
    chk("stopped", 0, cp + cc + cd + cb);
    rd_reg(4'h8, s);
    chk("ticks", 0, s);
    rd_reg(4'h4, s);
    chk("ctrl", 0, s);
    rd_reg(4'hC, s);
    chk("unmapped", 0, s);
  endtask

  task automatic end_sim();
    if (miscompares == 0 && checks > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence: every platform code, core codes cycled, async mode random
  initial
  begin
    repeat (6) @(posedge clk);
    for (int i = 0; i < 16; i++)
    begin
      seed = lfsr(seed);
      run_cfg(i, i % 8, seed[3]);
    end
    end_sim();
  end

  // Watchdog sized well above the sixteen configurations
  initial
  begin
    repeat (30000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
